// ---- ipt_pipeline.sv ----
// Function
// - One-clock fetch low routes bus data inward
// - Two-clock fetch low marks pipeline flush
// - Fetch indicated for user and supervisor
// - Two-clock bus: flush then fetch merges three
// - Slow buses negate fetch between indications
// - Three stages: buffer, decode, execute decode
// - One-clock pipe low consumes decode stage
// - Two-clock pipe low starts new instruction
// - Loaded words fall through empty stages
// - Validity set on receiver, cleared on supplier
// - Pipe indicator synchronous to system clock
// - Execute stage loads only at instruction start
// - Immediate start plus advance stays merged
// - Loop mode keeps pipe indications going
// - Loop mode fetch stops during recirculation
// - Each stage holds bus error status bit
// - Busy bus queues request until done
// - Prefetch starts at sequencer address, refills
// - Prefetch after the flush fetch only with room, no flow change
// - Operand accesses beat prefetches
module ipt_pipeline
  import ipt_pkg::*;
#(
  parameter int W = WORD_W,
  parameter int AW = ADDR_W,
  parameter int BUS_CLKS = 2
) (
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Sequencer control
  input wire logic seq_start_req,
  input wire logic [AW-1:0] seq_start_addr,
  input wire logic seq_use_ext,
  input wire logic seq_instr_start,
  input wire logic seq_cof_next,
  input wire logic seq_loop_mode,
  input wire logic seq_supervisor,
  input wire logic seq_opnd_req,
  input wire logic seq_opnd_we,
  input wire logic [AW-1:0] seq_opnd_addr,
  input wire logic [W-1:0] seq_opnd_wdata,
  // External bus
  input wire logic bus_done,
  input wire logic bus_err,
  input wire logic [W-1:0] bus_rdata,
  output logic bus_start,
  output logic bus_we,
  output logic bus_super,
  output logic [AW-1:0] bus_addr,
  output logic [W-1:0] bus_wdata,
  output logic bus_is_fetch,
  // Pipeline view
  output logic [W-1:0] decode_word,
  output logic decode_valid,
  output logic decode_err,
  output logic [W-1:0] exec_word,
  output logic exec_err,
  output logic opnd_done,
  output logic [W-1:0] opnd_rdata,
  // Tracking pins
  output logic instr_fetch_indicator_n,
  output logic pipe_advance_indicator_n
);
  // ------------------------------------------------------------
  // Pipeline stages
  // ------------------------------------------------------------
  logic [W-1:0] prefetch_buffer_stage_ff, decode_stage_ff, execute_decode_stage_ff;
  logic buf_vld_ff, dec_vld_ff;
  logic buf_err_ff, dec_err_ff, exe_err_ff;
  logic [AW-1:0] fetch_addr_ff;
  logic flush_pend_ff, recirc_ff, loop_seen_ff;
  ipt_bus_t bus_st_ff;
  logic opnd_pend_ff, opnd_we_ff;
  logic [AW-1:0] opnd_addr_ff;
  logic [W-1:0] opnd_wdata_ff;
  logic fetch_done, fetch_in, inflight_fetch;
  logic adv_full, adv_use;
  logic start_fetch, start_opnd;
  logic bus_start_ff, bus_we_ff, bus_super_ff, bus_fetch_ff;
  logic [AW-1:0] bus_addr_ff;
  logic [W-1:0] bus_wdata_ff;
  logic opnd_done_ff;
  logic [W-1:0] opnd_rdata_ff;
  logic fetch_flush_ff;

  assign fetch_done = (bus_st_ff == IPT_BUS_PREFETCH) && bus_done;
  assign inflight_fetch = (bus_st_ff == IPT_BUS_PREFETCH);
  // Words from a fetch that completes in the flush cycle are dropped
  assign fetch_in = fetch_done && !seq_start_req;
  assign adv_full = seq_instr_start && dec_vld_ff;
  assign adv_use = seq_use_ext && !seq_instr_start && dec_vld_ff;

  // Buffer stage
  always_ff @(posedge clk_sys) begin
    if (!rstn || seq_start_req) begin
      buf_vld_ff <= 1'b0;
      buf_err_ff <= 1'b0;
      prefetch_buffer_stage_ff <= '0;
    end else if (fetch_in && buf_vld_ff && !(adv_full || adv_use)) begin
      buf_vld_ff <= 1'b1;
    end else if (fetch_in && (buf_vld_ff || (dec_vld_ff && !(adv_full || adv_use)))) begin
      // Word held in buffer while decode stage stays occupied
      prefetch_buffer_stage_ff <= bus_rdata;
      buf_err_ff <= bus_err;
      buf_vld_ff <= 1'b1;
    end else if ((adv_full || adv_use) && buf_vld_ff) begin
      buf_vld_ff <= 1'b0;
    end
  end

  // Decode stage
  always_ff @(posedge clk_sys) begin
    if (!rstn || seq_start_req) begin
      dec_vld_ff <= 1'b0;
      dec_err_ff <= 1'b0;
      decode_stage_ff <= '0;
    end else if (adv_full || adv_use) begin
      if (buf_vld_ff) begin
        decode_stage_ff <= prefetch_buffer_stage_ff;
        dec_err_ff <= buf_err_ff;
        dec_vld_ff <= 1'b1;
      end else if (fetch_in) begin
        decode_stage_ff <= bus_rdata;
        dec_err_ff <= bus_err;
        dec_vld_ff <= 1'b1;
      end else begin
        dec_vld_ff <= 1'b0;
      end
    end else if (fetch_in && !dec_vld_ff) begin
      decode_stage_ff <= bus_rdata;
      dec_err_ff <= bus_err;
      dec_vld_ff <= 1'b1;
    end
  end

  // Execute decode stage
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      execute_decode_stage_ff <= '0;
      exe_err_ff <= 1'b0;
    end else if (adv_full) begin
      execute_decode_stage_ff <= decode_stage_ff;
      exe_err_ff <= dec_err_ff;
    end
  end

  // ------------------------------------------------------------
  // Prefetch controller
  // ------------------------------------------------------------
  logic room;
  // Count in-flight fetch as occupying a slot
  assign room = !(buf_vld_ff && dec_vld_ff) && !(inflight_fetch && (buf_vld_ff || dec_vld_ff));

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fetch_addr_ff <= RESET_ADDR;
      flush_pend_ff <= 1'b0;
    end else if (seq_start_req) begin
      fetch_addr_ff <= seq_start_addr;
      flush_pend_ff <= 1'b1;
    end else if (start_fetch) begin
      fetch_addr_ff <= fetch_addr_ff + FETCH_STEP[AW-1:0];
      flush_pend_ff <= 1'b0;
    end
  end

  // Loop mode: recirculation begins once the pipeline is full in loop mode
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      recirc_ff <= 1'b0;
      loop_seen_ff <= 1'b0;
    end else begin
      loop_seen_ff <= seq_loop_mode;
      if (!seq_loop_mode) begin
        recirc_ff <= 1'b0;
      end else if (buf_vld_ff && dec_vld_ff) begin
        recirc_ff <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Bus controller
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      opnd_pend_ff <= 1'b0;
      opnd_we_ff <= 1'b0;
      opnd_addr_ff <= '0;
      opnd_wdata_ff <= '0;
    end else if (seq_opnd_req) begin
      opnd_pend_ff <= 1'b1;
      opnd_we_ff <= seq_opnd_we;
      opnd_addr_ff <= seq_opnd_addr;
      opnd_wdata_ff <= seq_opnd_wdata;
    end else if (start_opnd) begin
      opnd_pend_ff <= 1'b0;
    end
  end

  logic bus_free;
  assign bus_free = (bus_st_ff == IPT_BUS_IDLE) || bus_done;
  assign start_opnd = bus_free && opnd_pend_ff && !bus_start_ff;
  assign start_fetch = bus_free && !opnd_pend_ff && !seq_opnd_req && !bus_start_ff &&
    !seq_start_req && !recirc_ff && (flush_pend_ff || (room && !seq_cof_next));

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      bus_st_ff <= IPT_BUS_IDLE;
      bus_start_ff <= 1'b0;
      bus_we_ff <= 1'b0;
      bus_fetch_ff <= 1'b0;
      bus_super_ff <= 1'b0;
      bus_addr_ff <= '0;
      bus_wdata_ff <= '0;
    end else begin
      bus_start_ff <= start_opnd || start_fetch;
      if (start_opnd) begin
        bus_st_ff <= IPT_BUS_OPERAND;
        bus_we_ff <= opnd_we_ff;
        bus_fetch_ff <= 1'b0;
        bus_addr_ff <= opnd_addr_ff;
        bus_wdata_ff <= opnd_wdata_ff;
        bus_super_ff <= seq_supervisor;
      end else if (start_fetch) begin
        bus_st_ff <= IPT_BUS_PREFETCH;
        bus_we_ff <= 1'b0;
        bus_fetch_ff <= 1'b1;
        bus_addr_ff <= fetch_addr_ff;
        bus_super_ff <= seq_supervisor;
      end else if (bus_done) begin
        bus_st_ff <= IPT_BUS_IDLE;
        bus_fetch_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      opnd_done_ff <= 1'b0;
      opnd_rdata_ff <= '0;
    end else begin
      opnd_done_ff <= (bus_st_ff == IPT_BUS_OPERAND) && bus_done;
      if ((bus_st_ff == IPT_BUS_OPERAND) && bus_done) begin
        opnd_rdata_ff <= bus_rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // Tracking indicators
  // ------------------------------------------------------------
  ipt_pulse_if fetch_pif ();
  ipt_pulse_if pipe_pif ();

  // Flush marking follows the fetch into the pulse start
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fetch_flush_ff <= 1'b0;
    end else begin
      fetch_flush_ff <= start_fetch && flush_pend_ff;
    end
  end

  // Indication issued with the bus start of each fetch cycle; a new fetch
  // on a two-clock bus lands on the flush pulse's last clock and merges,
  // slower buses leave a gap because starts are further apart.
  assign fetch_pif.req = bus_start_ff && bus_fetch_ff && !recirc_ff;
  assign fetch_pif.len = fetch_flush_ff ? FETCH_LEN_FLUSH : FETCH_LEN_NORMAL;

  // Pipe pulse driven on clk_sys only; start beats use when both occur
  assign pipe_pif.req = adv_full || adv_use;
  assign pipe_pif.len = adv_full ? PIPE_LEN_START : PIPE_LEN_USE;

  ipt_pulse_gen u_fetch_pulse (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pif(fetch_pif.gen)
  );

  ipt_pulse_gen u_pipe_pulse (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .pif(pipe_pif.gen)
  );

  // ------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------
  logic fetch_n_ff, pipe_n_ff;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fetch_n_ff <= 1'b1;
      pipe_n_ff <= 1'b1;
    end else begin
      fetch_n_ff <= fetch_pif.out_n;
      pipe_n_ff <= pipe_pif.out_n;
    end
  end

  assign instr_fetch_indicator_n = fetch_n_ff;
  assign pipe_advance_indicator_n = pipe_n_ff;
  assign bus_start = bus_start_ff;
  assign bus_we = bus_we_ff;
  assign bus_super = bus_super_ff;
  assign bus_addr = bus_addr_ff;
  assign bus_wdata = bus_wdata_ff;
  assign bus_is_fetch = bus_fetch_ff;
  assign decode_word = decode_stage_ff;
  assign decode_valid = dec_vld_ff;
  assign decode_err = dec_err_ff;
  assign exec_word = execute_decode_stage_ff;
  assign exec_err = exe_err_ff;
  assign opnd_done = opnd_done_ff;
  assign opnd_rdata = opnd_rdata_ff;
endmodule : ipt_pipeline

// ---- ipt_pkg.sv ----
package ipt_pkg;
  // Word width of one instruction word
  localparam int WORD_W = 16;
  localparam int ADDR_W = 24;
  // Fetch indicator pulse widths in clocks
  localparam logic [1:0] FETCH_LEN_NORMAL = 2'h1;
  localparam logic [1:0] FETCH_LEN_FLUSH = 2'h2;
  // Pipe indicator pulse widths in clocks
  localparam logic [1:0] PIPE_LEN_USE = 2'h1;
  localparam logic [1:0] PIPE_LEN_START = 2'h2;
  // Address increment per prefetched word in bytes
  localparam logic [23:0] FETCH_STEP = 24'h000002;
  localparam logic [23:0] RESET_ADDR = 24'h000000;
  typedef enum logic [1:0] {
    IPT_BUS_IDLE,
    IPT_BUS_OPERAND,
    IPT_BUS_PREFETCH
  } ipt_bus_t;
endpackage : ipt_pkg

// ---- ipt_pulse_if.sv ----
interface ipt_pulse_if;
  logic req;
  logic [1:0] len;
  logic busy;
  logic out_n;
  modport gen (input req, input len, output busy, output out_n);
  modport user (output req, output len, input busy, input out_n);
endinterface : ipt_pulse_if

// ---- ipt_pulse_gen.sv ----
// Stretches a request into an active-low pulse of len clocks; a request on the
// last clock of a pulse extends it with no gap (merged indications).
module ipt_pulse_gen
  import ipt_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Pulse request and output
  ipt_pulse_if.gen pif
);
  logic [2:0] cnt_ff;
  logic out_n_ff;

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_ff <= 3'h0;
      out_n_ff <= 1'b1;
    end else if (pif.req) begin
      cnt_ff <= {1'b0, pif.len} + ((cnt_ff > 3'h1) ? cnt_ff - 3'h1 : 3'h0);
      out_n_ff <= 1'b0;
    end else if (cnt_ff > 3'h1) begin
      cnt_ff <= cnt_ff - 3'h1;
      out_n_ff <= 1'b0;
    end else begin
      cnt_ff <= 3'h0;
      out_n_ff <= 1'b1;
    end
  end

  assign pif.out_n = out_n_ff;
  assign pif.busy = (cnt_ff > 3'h1);
endmodule : ipt_pulse_gen

// ---- ipt_pipeline_sva.sv ----
module ipt_pipeline_sva
  import ipt_pkg::*;
#(
  parameter int W = WORD_W,
  parameter int AW = ADDR_W
) (
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Requests
  input wire logic seq_start_req,
  input wire logic [AW-1:0] seq_start_addr,
  input wire logic seq_use_ext,
  input wire logic seq_instr_start,
  // Bus and pipeline
  input wire logic bus_done,
  input wire logic bus_start,
  input wire logic bus_is_fetch,
  input wire logic [AW-1:0] bus_addr,
  input wire logic decode_valid,
  input wire logic opnd_done,
  // Tracking pins
  input wire logic instr_fetch_indicator_n,
  input wire logic pipe_advance_indicator_n
);
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> instr_fetch_indicator_n &&
    pipe_advance_indicator_n && !decode_valid && !bus_start) else $error("reset state wrong");
  a_fetch_marks: assert property (bus_start && bus_is_fetch |-> ##2 !instr_fetch_indicator_n)
    else $error("fetch start not marked");
  a_fetch_cause: assert property ($fell(instr_fetch_indicator_n) |->
    $past(bus_start && bus_is_fetch, 2)) else $error("fetch mark without fetch");
  a_fetch_merge_max: assert property (!instr_fetch_indicator_n [*3] |=>
    instr_fetch_indicator_n) else $error("fetch mark longer than three");
  a_ext_pulse: assert property (seq_use_ext && decode_valid |-> ##2
    !pipe_advance_indicator_n) else $error("extension use not shown");
  a_start_pulse: assert property (seq_instr_start && decode_valid |-> ##2
    !pipe_advance_indicator_n [*2]) else $error("instruction start not shown");
  a_pipe_cause: assert property ($fell(pipe_advance_indicator_n) |->
    $past(seq_use_ext, 2) || $past(seq_instr_start, 2)) else $error("pipe mark without cause");
  a_start_addr: assert property (bus_start && $past(seq_start_req, 2) |-> bus_is_fetch &&
    bus_addr == $past(seq_start_addr, 2)) else $error("flush fetch address wrong");
  a_start_gap: assert property (bus_start |=> !bus_start) else $error("bus starts adjacent");
  a_opnd_done: assert property (opnd_done |-> $past(bus_done))
    else $error("operand done without bus done");
endmodule : ipt_pipeline_sva

bind ipt_pipeline ipt_pipeline_sva #(.W(W), .AW(AW)) u_sva (.clk_sys, .rstn, .seq_start_req,
  .seq_start_addr, .seq_use_ext, .seq_instr_start, .bus_done, .bus_start, .bus_is_fetch,
  .bus_addr, .decode_valid, .opnd_done, .instr_fetch_indicator_n, .pipe_advance_indicator_n);

// ---- ipt_bus_model.sv ----
module ipt_bus_model
  import ipt_pkg::*;
(
  // System
  input wire logic clk_sys,
  input wire logic rstn,
  // Bus from the device
  input wire logic bus_start,
  input wire logic [ADDR_W-1:0] bus_addr,
  // Latency and faulting address
  input wire logic [1:0] lat,
  input wire logic [ADDR_W-1:0] err_addr,
  // Answer
  output logic bus_done,
  output logic bus_err,
  output logic [WORD_W-1:0] bus_rdata
);
  // ----
  // Memory
  // ----
  logic [1:0] wait_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] cur;
  logic fire;
  assign cur = bus_start ? bus_addr : addr_ff;
  assign fire = (bus_start && lat == 2'h1) || wait_ff == 2'h1;
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      wait_ff <= 2'h0;
      addr_ff <= 24'h0;
      bus_done <= 1'b0;
      bus_err <= 1'b0;
      bus_rdata <= 16'h0;
    end else begin
      bus_done <= fire;
      bus_err <= fire && cur == err_addr;
      // Released data lines toggle rather than hold
      bus_rdata <= fire ? (cur[16:1] ^ 16'h5a5a) : ~bus_rdata;
      if (bus_start) begin
        addr_ff <= bus_addr;
        wait_ff <= lat - 2'h1;
      end else if (wait_ff != 2'h0) begin
        wait_ff <= wait_ff - 2'h1;
      end
    end
  end
endmodule : ipt_bus_model

// ---- instruction_pipeline_opcode_tracking_test.sv ----
module instruction_pipeline_opcode_tracking_test
  import ipt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'h0, rstn = 1'h0, seq_start_req = 1'h0, seq_use_ext = 1'h0;
  logic seq_instr_start = 1'h0, seq_cof_next = 1'h0, seq_loop_mode = 1'h0, seq_supervisor = 1'h0;
  logic seq_opnd_req = 1'h0, seq_opnd_we = 1'h0, bus_done, bus_err, bus_start, bus_we, bus_super;
  logic bus_is_fetch, decode_valid, decode_err, exec_err, opnd_done;
  logic instr_fetch_indicator_n, pipe_advance_indicator_n;
  logic [23:0] seq_start_addr = 24'h0, seq_opnd_addr = 24'h0, err_addr = 24'hffffff, a, bus_addr;
  logic [15:0] seq_opnd_wdata = 16'h0, bus_rdata, bus_wdata, decode_word, exec_word, opnd_rdata;
  logic [1:0] lat = 2'h1;
  int mismatches = 0, tests_run = 0, run = 0, nf = 0, nf_op = 0, cycles = 0;
  int runs[$];
  int prun = 0;
  int pruns[$];
  ipt_pipeline dut (.clk_sys, .rstn, .seq_start_req, .seq_start_addr, .seq_use_ext,
    .seq_instr_start, .seq_cof_next, .seq_loop_mode, .seq_supervisor, .seq_opnd_req,
    .seq_opnd_we, .seq_opnd_addr, .seq_opnd_wdata, .bus_done, .bus_err, .bus_rdata, .bus_start,
    .bus_we, .bus_super, .bus_addr, .bus_wdata, .bus_is_fetch, .decode_word, .decode_valid,
    .decode_err, .exec_word, .exec_err, .opnd_done, .opnd_rdata, .instr_fetch_indicator_n,
    .pipe_advance_indicator_n);
  ipt_bus_model bm (.clk_sys, .rstn, .bus_start, .bus_addr, .lat, .err_addr, .bus_done,
    .bus_err, .bus_rdata);
  // ----
  // Helpers
  // ----
  initial forever #20 clk_sys = ~clk_sys;
  function automatic logic [15:0] mw(logic [23:0] x);
    return x[16:1] ^ 16'h5a5a;
  endfunction : mw
  task automatic chk_w(string s, logic [15:0] e, logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s exp %h got %h", s, e, g);
    end
  endtask : chk_w
  task automatic chk_n(string s, int e, int g);
    tests_run++;
    if (g != e) begin
      mismatches++;
      $display("FAIL %s exp %0d got %0d", s, e, g);
    end
  endtask : chk_n
  task automatic cyc(int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic flush(logic [23:0] x);
    seq_start_addr = x;
    seq_start_req = 1'h1;
    cyc(1);
    seq_start_req = 1'h0;
    runs.delete();
    pruns.delete();
    nf = 0;
  endtask : flush
  task automatic ext();
    seq_use_ext = 1'h1;
    cyc(1);
    seq_use_ext = 1'h0;
  endtask : ext
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      tally_and_finish();
    end
    if (instr_fetch_indicator_n === 1'h0) run++;
    else if (run != 0) begin
      runs.push_back(run);
      run = 0;
    end
    if (bus_start === 1'h1 && bus_is_fetch === 1'h1) begin
      nf++;
      chk_w("bus_super", {15'h0, seq_supervisor}, {15'h0, bus_super});
    end
    if (bus_start === 1'h1 && bus_is_fetch === 1'h0) nf_op = nf;
  end
  // Pipe marks sampled on the falling edge and split into runs
  always @(negedge clk_sys) begin
    if (pipe_advance_indicator_n === 1'h0) prun++;
    else if (prun != 0) begin
      pruns.push_back(prun);
      prun = 0;
    end
  end
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(18));
    cyc(6);
    rstn = 1'h1;
    chk_w("idle marks", 16'h3, {14'h0, instr_fetch_indicator_n, pipe_advance_indicator_n});
    for (int i = 0; i < 4; i++) begin
      lat = (i == 0) ? 2'h1 : ((i > 1 && $urandom_range(1) == 1) ? 2'h3 : 2'h2);
      seq_supervisor = i[0];
      a = 24'($urandom) & 24'hfffffe;
      flush(a);
      cyc(20);
      chk_w("decode_word", mw(a), decode_word);
      chk_n("flush mark", (lat == 2'h1) ? 3 : 2, runs.size() > 0 ? runs[0] : 0);
      chk_n("fetch count", 2, nf);
      seq_instr_start = 1'h1;
      cyc(1);
      seq_instr_start = 1'h0;
      cyc(i[0] ? 0 : 8);
      ext();
      cyc(16);
      chk_w("exec_word", mw(a), exec_word);
      chk_w("decode after use", mw(a + 24'h4), decode_word);
      chk_n("pipe start mark", i[0] ? 3 : 2, pruns.size() > 0 ? pruns[0] : 0);
      chk_n("pipe use mark", i[0] ? 0 : 1, pruns.size() > 1 ? pruns[1] : 0);
      $display("test advance %0d done", i);
    end
    err_addr = 24'h000100;
    flush(err_addr);
    cyc(20);
    chk_w("decode_err", 16'h1, {15'h0, decode_err});
    err_addr = 24'hffffff;
    $display("test fault done");
    flush(24'h000200);
    cyc(1);
    seq_opnd_addr = 24'($urandom) & 24'hfffffe;
    seq_opnd_wdata = 16'($urandom);
    seq_opnd_req = 1'h1;
    cyc(1);
    seq_opnd_req = 1'h0;
    for (int k = 0; k < 40 && opnd_done !== 1'h1; k++) cyc(1);
    chk_w("opnd_rdata", mw(seq_opnd_addr), opnd_rdata);
    chk_n("fetches before operand", 1, nf_op);
    $display("test operand done");
    cyc(20);
    seq_cof_next = 1'h1;
    flush(24'h000400);
    cyc(20);
    chk_n("fetches with flow change", 1, nf);
    seq_cof_next = 1'h0;
    seq_loop_mode = 1'h1;
    flush(24'h000600);
    cyc(20);
    ext();
    cyc(12);
    chk_n("loop fetches", 2, nf);
    seq_loop_mode = 1'h0;
    cyc(12);
    chk_n("fetches after loop", 3, nf);
    $display("test loop done");
    tally_and_finish();
  end
endmodule : instruction_pipeline_opcode_tracking_test
